// ---- hdl/sfi_pkg.sv ----
package sfi_pkg;
  // command codes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_SSWR = 8'h42;
  localparam logic [7:0] OP_SSRD = 8'h4b;
  localparam logic [7:0] OP_RDID = 8'h9f;
  localparam logic [7:0] OP_RUID = 8'h4c;
  localparam logic [7:0] OP_WRSN = 8'hc2;
  localparam logic [7:0] OP_RDSN = 8'hc3;
  // status register fields
  localparam int SR_PROTECT_PIN_ENABLE_BIT = 7;
  localparam int SR_BP_LSB = 2;
  localparam int SR_WEL_BIT = 1;
  localparam logic [1:0] SR_BP_RST = 2'h0;
  localparam logic SR_PROTECT_PIN_ENABLE_RST = 1'b0;
  // block protect encodings
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  // framing
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int ID_BYTES = 8;
  // synchroniser reset: {cs_n, sck, si, wp_n}
  localparam logic [3:0] SYNC_RST = 4'h9;
  typedef enum logic [1:0] {
    ST_CMD  = 2'b00,
    ST_ADDR = 2'b01,
    ST_WR   = 2'b10,
    ST_RD   = 2'b11
  } sfi_state_e;
  typedef enum logic {
    ST_LIVE = 1'b0,
    ST_IGN  = 1'b1
  } sfi_ign_e;
endpackage

// ---- hdl/sfi_slave.sv ----
`timescale 1ns/1ns
// Operation
// - active only while chip select is low
// - deselected: ignore inputs, output tristated
// - new command only after chip select falls
// - sample on rising, shift out on falling
// - clock rate well below core clock, state kept across pauses
// - serial input looked at only on rising
// - output driven only while returning read data
// - protect pin low and enable bit block status
// - each byte committed as soon as complete
// - byte-wide array, one location per address
// - works in mode 0 and mode 3
// - write-disable command blocks writes
// - quarter, half or whole array protect
// - separate 256-byte special sector
// - writable 8-byte serial number
// - read-only identification data
// - three address bytes, top four ignored
// - first byte after select is command
// - unknown command: ignore rest, stay tristated
// - most significant bit first both ways
module sfi_slave
  import sfi_pkg::*;
#(
  parameter int          ADDR_W   = 20,
  parameter int          SS_BYTES = 256,
  parameter int          SN_BYTES = 8,
  // identification values are arbitrary
  parameter logic [63:0] DEV_ID   = 64'h0102030405060708,
  parameter logic [63:0] UNIQ_ID  = 64'h1122334455667788
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic wp_n,
  output logic      so,
  output logic      so_oe_n
);

  // refuse sizes that the address and index decode cannot serve
  generate
    if (ADDR_W < 2 || ADDR_W > 24 || SS_BYTES != 256 || SN_BYTES != ID_BYTES) begin : g_chk
      $error("sfi_slave: unsupported parameter values");
    end
  endgenerate

  logic [7:0]       mem [0:(1<<ADDR_W)-1];
  logic [7:0]       ss_mem [0:SS_BYTES-1];
  logic [7:0]       sn_mem [0:SN_BYTES-1];

  logic [3:0]       sync1;
  logic [3:0]       sync2;
  logic [3:0]       sync3;
  logic [3:0]       filt;
  logic             sck_prev;
  logic             act;
  logic             act_prev;
  logic             sck_rise;
  logic             sck_fall;
  logic             f_si;
  logic             f_wp_n;
  sfi_state_e       state;
  sfi_ign_e         ign;
  logic [7:0]       cmd;
  logic [2:0]       bitcnt;
  logic [7:0]       rxsh;
  logic [1:0]       addr_cnt;
  logic [23:0]      addr;
  logic [7:0]       tx;
  logic             wel;
  logic             protect_pin_enable_bit;
  logic [1:0]       sr_bp;
  logic [7:0]       rx_byte;
  logic             byte_done;
  logic [7:0]       cur_op;
  logic [23:0]      next_addr;
  logic [23:0]      src_addr;
  logic [7:0]       tx_next;
  logic             tx_load;
  logic             wr_byte;
  logic             sr_locked;
  logic [7:0]       status;

  function automatic logic blocked(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    logic r;
    r = 1'b0;
    if (bp == BP_ALL) begin
      r = 1'b1;
    end else if (bp == BP_HALF) begin
      r = a[ADDR_W-1];
    end else if (bp == BP_QUARTER) begin
      r = &a[ADDR_W-1 -: 2];
    end
    return r;
  endfunction

  function automatic logic [7:0] id_byte(input logic [63:0] v, input logic [2:0] i);
    return v[8*(7-i) +: 8];
  endfunction

  function automatic logic is_wr_cmd(input logic [7:0] op);
    return op == OP_WRITE || op == OP_SSWR || op == OP_WRSN || op == OP_WRSR;
  endfunction

  // three-stage input capture; a change counts once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      sync3 <= SYNC_RST;
      filt  <= SYNC_RST;
    end else begin
      sync1 <= {cs_n, sck, si, wp_n};
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= (sync2 & sync3) | (filt & (sync2 | sync3));
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_prev <= 1'b0;
      act_prev <= 1'b0;
    end else begin
      sck_prev <= filt[2];
      act_prev <= act;
    end
  end

  assign act      = ~filt[3];
  assign f_si     = filt[1];
  assign f_wp_n   = filt[0];
  // edges only from a level change seen while selected, so mode 3 idle-high start is safe
  assign sck_rise = act & act_prev & filt[2] & ~sck_prev;
  assign sck_fall = act & act_prev & ~filt[2] & sck_prev;
  assign rx_byte  = {rxsh[6:0], f_si};
  assign byte_done = sck_rise && bitcnt == BIT_LAST && ign == ST_LIVE;
  assign cur_op   = (state == ST_CMD) ? rx_byte : cmd;
  assign next_addr = {addr[15:0], rx_byte};
  // command-only reads start at index 0, not at an address left from the last frame
  always_comb begin
    src_addr = addr;
    if (state == ST_ADDR) begin
      src_addr = next_addr;
    end else if (state == ST_CMD) begin
      src_addr = 24'h000000;
    end
  end

  assign status   = {protect_pin_enable_bit, 3'h0, sr_bp, wel, 1'b0};
  assign sr_locked = ~f_wp_n & protect_pin_enable_bit;
  assign wr_byte  = byte_done && state == ST_WR && wel;

  always_comb begin
    tx_next = 8'h00;
    if (cur_op == OP_READ) begin
      tx_next = mem[src_addr[ADDR_W-1:0]];
    end else if (cur_op == OP_SSRD) begin
      tx_next = ss_mem[src_addr[7:0]];
    end else if (cur_op == OP_RDSR) begin
      tx_next = status;
    end else if (cur_op == OP_RDID) begin
      tx_next = id_byte(DEV_ID, src_addr[2:0]);
    end else if (cur_op == OP_RUID) begin
      tx_next = id_byte(UNIQ_ID, src_addr[2:0]);
    end else if (cur_op == OP_RDSN) begin
      tx_next = sn_mem[src_addr[2:0]];
    end
  end

  assign tx_load = byte_done && (state == ST_RD ||
                   (state == ST_CMD && (rx_byte == OP_RDSR || rx_byte == OP_RDID ||
                    rx_byte == OP_RUID || rx_byte == OP_RDSN)) ||
                   (state == ST_ADDR && addr_cnt == ADDR_LAST &&
                    (cmd == OP_READ || cmd == OP_SSRD)));

  // framing state; deselect resets state, ignore flag and bit count, so partial bytes vanish
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= ST_CMD;
      ign      <= ST_LIVE;
      cmd      <= 8'h00;
      bitcnt   <= 3'h0;
      rxsh     <= 8'h00;
      addr_cnt <= 2'h0;
      addr     <= 24'h000000;
    end else if (!act) begin
      state  <= ST_CMD;
      ign    <= ST_LIVE;
      bitcnt <= 3'h0;
    end else if (sck_rise && ign == ST_LIVE) begin
      bitcnt <= bitcnt + 3'h1;
      rxsh   <= rx_byte;
      if (bitcnt == BIT_LAST) begin
        case (state)
          ST_CMD: begin
            cmd      <= rx_byte;
            addr     <= 24'h000000;
            addr_cnt <= 2'h0;
            if (rx_byte == OP_READ || rx_byte == OP_WRITE ||
                rx_byte == OP_SSWR || rx_byte == OP_SSRD) begin
              state <= ST_ADDR;
            end else if (rx_byte == OP_WRSR || rx_byte == OP_WRSN) begin
              state <= ST_WR;
            end else if (rx_byte == OP_RDSR || rx_byte == OP_RDID ||
                         rx_byte == OP_RUID || rx_byte == OP_RDSN) begin
              state <= ST_RD;
              addr  <= 24'h000001;
            end else begin
              ign <= ST_IGN;
            end
          end
          ST_ADDR: begin
            addr_cnt <= addr_cnt + 2'h1;
            addr     <= next_addr;
            if (addr_cnt == ADDR_LAST) begin
              if (cmd == OP_READ || cmd == OP_SSRD) begin
                state <= ST_RD;
                addr  <= next_addr + 24'h000001;
              end else begin
                state <= ST_WR;
              end
            end
          end
          ST_WR: begin
            addr <= addr + 24'h000001;
          end
          ST_RD: begin
            addr <= addr + 24'h000001;
          end
          default: begin
            state <= ST_CMD;
          end
        endcase
      end
    end
  end

  // read shifter: load at byte end, bits leave on falling edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx      <= 8'h00;
      so      <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (!act) begin
      so_oe_n <= 1'b1;
    end else if (tx_load) begin
      tx <= tx_next;
    end else if (sck_fall && state == ST_RD) begin
      so      <= tx[7];
      tx      <= {tx[6:0], 1'b0};
      so_oe_n <= 1'b0;
    end else if (state != ST_RD) begin
      so_oe_n <= 1'b1;
    end
  end

  // status, write latch; latch drops after a write-type command ends
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wel                    <= 1'b0;
      protect_pin_enable_bit <= SR_PROTECT_PIN_ENABLE_RST;
      sr_bp                  <= SR_BP_RST;
    end else if (act_prev && !act && state != ST_CMD && is_wr_cmd(cmd)) begin
      wel <= 1'b0;
    end else if (byte_done && state == ST_CMD && rx_byte == OP_WREN) begin
      wel <= 1'b1;
    end else if (byte_done && state == ST_CMD && rx_byte == OP_WRITE_DISABLE) begin
      wel <= 1'b0;
    end else if (wr_byte && cmd == OP_WRSR && !sr_locked) begin
      protect_pin_enable_bit <= rx_byte[SR_PROTECT_PIN_ENABLE_BIT];
      sr_bp                  <= rx_byte[SR_BP_LSB +: 2];
    end
  end

  // a byte aimed at a protected range is dropped without any notice
  always_ff @(posedge core_clk) begin
    if (wr_byte && cmd == OP_WRITE && !blocked(addr[ADDR_W-1:0], sr_bp)) begin
      mem[addr[ADDR_W-1:0]] <= rx_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_byte && cmd == OP_SSWR) begin
      ss_mem[addr[7:0]] <= rx_byte;
    end
  end

  // serial number clears on reset; array and special sector keep their contents
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SN_BYTES; i++) begin
        sn_mem[i] <= 8'h00;
      end
    end else if (wr_byte && cmd == OP_WRSN) begin
      sn_mem[addr[2:0]] <= rx_byte;
    end
  end

endmodule

// ---- dv/sfi_slave_properties.sv ----
`timescale 1ns/1ns
module sfi_slave_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_STANDBY: assert property (cs_n [*8] |-> so_oe_n && $stable(so))
    else $error("output active or moving while deselected");
  AST_OE_NEEDS_SEL: assert property ($fell(so_oe_n) |-> !$past(cs_n, 4))
    else $error("output enabled without chip select");
  AST_OE_ON_SCK_FALL: assert property ($fell(so_oe_n) |-> !$past(sck, 2))
    else $error("output enabled away from a falling clock");
  AST_OE_KEPT: assert property (!so_oe_n && !cs_n |=> !so_oe_n)
    else $error("output dropped during a read");
  AST_OE_OFF_CAUSE: assert property ($rose(so_oe_n) |-> $past(cs_n, 3))
    else $error("output released while selected");
  AST_OE_OFF_QUICK: assert property ($rose(cs_n) |-> ##[1:8] so_oe_n)
    else $error("output not released after deselect");
  AST_SO_ON_FALL: assert property (
    !so_oe_n && $past(!so_oe_n) && $changed(so) |-> !$past(sck, 2))
    else $error("data changed away from a falling clock");
  AST_SO_HOLD: assert property (!so_oe_n && sck && $past(sck, 6) |-> $stable(so))
    else $error("data moved while clock held high");
endmodule

bind sfi_slave sfi_slave_chk i_chk (
  .core_clk (core_clk),
  .rst      (rst),
  .cs_n     (cs_n),
  .sck      (sck),
  .si       (si),
  .wp_n     (wp_n),
  .so       (so),
  .so_oe_n  (so_oe_n)
);

// ---- dv/sfi_spi_master.sv ----
`timescale 1ns/1ns
module sfi_spi_master (
  input  wire logic core_clk,
  input  wire logic so,
  input  wire logic so_oe_n,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  logic mode3 = 1'b0;
  logic last  = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // 13 core cycles per half period, about 10 MHz
  task automatic half();
    repeat (13) @(posedge core_clk);
    #1;
  endtask
  task automatic sel(input logic on);
    sck = mode3; // idle level of the chosen mode
    half();
    cs_n = !on; // falling select ahead of every opcode
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    for (int i = 7; i > 7 - nbits; i--) begin
      sck = 1'b0;
      si  = tx[i]; // msb first
      half();
      sck = 1'b1;
      // released line shows the inverse of its last level
      last = so_oe_n ? ~last : so;
      rx[i] = last;
      half();
    end
  endtask
endmodule

// ---- dv/tb_spi_fram_slave_interface.sv ----
`timescale 1ns/1ns
module tb_spi_fram_slave_interface;
  import sfi_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst      = 1'b1;
  logic       wp_n     = 1'b1;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       so;
  logic       so_oe_n;
  int         n_oe_low        = 0;
  int         oe_base         = 0;
  logic [7:0] r;
  int         n_mismatch      = 0;
  int         samples_checked = 0;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (!so_oe_n) n_oe_low <= n_oe_low + 1;
  // identification values are arbitrary
  sfi_slave #(
    .DEV_ID  (64'h5a00000000000000),
    .UNIQ_ID (64'h3c00000000000000)
  ) i_dut (
    .core_clk (core_clk),
    .rst      (rst),
    .cs_n     (cs_n),
    .sck      (sck),
    .si       (si),
    .wp_n     (wp_n),
    .so       (so),
    .so_oe_n  (so_oe_n)
  );
  sfi_spi_master i_master (
    .core_clk (core_clk),
    .so       (so),
    .so_oe_n  (so_oe_n),
    .cs_n     (cs_n),
    .sck      (sck),
    .si       (si)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [7:0] q [$]);
    i_master.sel(1'b1);
    foreach (q[k]) i_master.xfer(q[k], 8, r);
    i_master.sel(1'b0);
  endtask
  task automatic t_rw(input logic m3);
    i_master.mode3 = m3;
    frame('{OP_WREN});
    frame('{OP_WRITE, 8'hf1, 8'h23, 8'h40, 8'ha5, 8'h3c});
    frame('{OP_READ, 8'h01, 8'h23, 8'h40, 8'h00});
    check(r, 8'ha5);
    frame('{OP_READ, 8'h01, 8'h23, 8'h41, 8'h00});
    check(r, 8'h3c);
    $display("test rw mode %0d done", m3);
  endtask
  task automatic t_block();
    frame('{OP_WREN});
    frame('{OP_WRITE_DISABLE});
    frame('{OP_WRITE, 8'h01, 8'h23, 8'h40, 8'h77});
    frame('{OP_WREN});
    i_master.sel(1'b1);
    i_master.xfer(OP_WRITE, 8, r);
    i_master.xfer(8'h01, 8, r);
    i_master.xfer(8'h23, 8, r);
    i_master.xfer(8'h40, 8, r);
    i_master.xfer(8'h11, 4, r);
    i_master.sel(1'b0);
    frame('{OP_READ, 8'h01, 8'h23, 8'h40, 8'h00});
    check(r, 8'ha5);
    oe_base = n_oe_low;
    frame('{8'hff, OP_READ, 8'h01, 8'h23, 8'h40, 8'h00});
    check({7'h0, n_oe_low != oe_base}, 8'h00);
    frame('{OP_READ, 8'h01, 8'h23, 8'h40, 8'h00});
    check(r, 8'ha5);
    $display("test write blocking done");
  endtask
  task automatic t_prot();
    frame('{OP_WREN});
    frame('{OP_WRITE, 8'h0c, 8'h00, 8'h00, 8'h11});
    frame('{OP_WREN});
    frame('{OP_WRSR, 8'h84});
    frame('{OP_WREN});
    frame('{OP_WRITE, 8'h0c, 8'h00, 8'h00, 8'h5a});
    frame('{OP_READ, 8'h0c, 8'h00, 8'h00, 8'h00});
    check(r, 8'h11);
    wp_n = 1'b0;
    frame('{OP_WREN});
    frame('{OP_WRSR, 8'h00});
    frame('{OP_RDSR, 8'h00});
    check(r, 8'h84);
    wp_n = 1'b1;
    frame('{OP_WREN});
    frame('{OP_WRSR, 8'h00});
    frame('{OP_RDSR, 8'h00});
    check(r, 8'h00);
    $display("test protection done");
  endtask
  task automatic wr_mem(input logic [7:0] hi, input logic [7:0] d);
    frame('{OP_WREN});
    frame('{OP_WRITE, hi, 8'h00, 8'h00, d});
  endtask
  task automatic rd_mem(input logic [7:0] hi);
    frame('{OP_READ, hi, 8'h00, 8'h00, 8'h00});
  endtask
  task automatic t_half_all();
    wr_mem(8'h08, 8'h44);
    wr_mem(8'h00, 8'h33);
    frame('{OP_WREN});
    frame('{OP_WRSR, 8'h08});
    wr_mem(8'h08, 8'h5a);
    wr_mem(8'h00, 8'h66);
    rd_mem(8'h08);
    check(r, 8'h44);
    rd_mem(8'h00);
    check(r, 8'h66);
    frame('{OP_WREN});
    frame('{OP_WRSR, 8'h0c});
    wr_mem(8'h00, 8'h5a);
    rd_mem(8'h00);
    check(r, 8'h66);
    frame('{OP_WREN});
    frame('{OP_WRSR, 8'h00});
    $display("test half and whole protect done");
  endtask
  task automatic t_ids();
    frame('{OP_WREN});
    frame('{OP_WRSN, 8'h6b});
    frame('{OP_RDSN, 8'h00});
    check(r, 8'h6b);
    frame('{OP_WREN});
    frame('{OP_SSWR, 8'h00, 8'h00, 8'h07, 8'hc9});
    frame('{OP_SSRD, 8'h00, 8'h00, 8'h07, 8'h00});
    check(r, 8'hc9);
    frame('{OP_RDID, 8'h00});
    check(r, 8'h5a);
    frame('{OP_RUID, 8'h00});
    check(r, 8'h3c);
    $display("test identity done");
  endtask
  task automatic t_reset();
    frame('{OP_WREN});
    frame('{OP_WRSR, 8'h84});
    frame('{OP_WREN});
    @(posedge core_clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    frame('{OP_RDSR, 8'h00});
    check(r, 8'h00);
    frame('{OP_RDSN, 8'h00});
    check(r, 8'h00);
    $display("test mid-run reset done");
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    t_rw(1'b0);
    t_rw(1'b1);
    t_block();
    t_prot();
    t_half_all();
    t_ids();
    t_reset();
    stop_test();
  end
endmodule
